// ---- design/ppm_pkg.sv ----
// ****************************************
// Shared constants of the pin override mux
// ****************************************
package ppm_pkg;

    localparam int          NUM_PINS          = 8;

    // ****************************************
    // Pin roles on the port
    // ****************************************
    localparam int          PIN_SERIAL_DATA   = 0;
    localparam int          PIN_SERIAL_OUT    = 1;
    localparam int          PIN_EXT_IRQ1      = 2;
    localparam int          PIN_CAPTURE       = 4;
    localparam logic [7:0]  PIN_EXT_IRQ1_MASK = 8'h04;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  PORT_RESET        = 8'h00;
    localparam logic [15:0] ANALOG_RESET      = 16'h0000;
    localparam logic [31:0] RDATA_RESET       = 32'h0000_0000;

    // ****************************************
    // Register offsets of the override controller
    // ****************************************
    localparam logic [11:0] REG_PULLUP_EN     = 12'h000;
    localparam logic [11:0] REG_PULLUP_VAL    = 12'h004;
    localparam logic [11:0] REG_DIR_EN        = 12'h008;
    localparam logic [11:0] REG_DIR_VAL       = 12'h00c;
    localparam logic [11:0] REG_VALUE_EN      = 12'h010;
    localparam logic [11:0] REG_VALUE_VAL     = 12'h014;
    localparam logic [11:0] REG_TOGGLE        = 12'h018;
    localparam logic [11:0] REG_INEN_EN       = 12'h01c;
    localparam logic [11:0] REG_INEN_VAL      = 12'h020;
    localparam logic [11:0] REG_ANALOG        = 12'h024;
    localparam logic [11:0] REG_STATUS        = 12'h028;
    localparam logic [11:0] REG_IRQ_CTRL      = 12'h02c;

    // Field positions
    localparam int          ANALOG_OE_LSB     = 0;
    localparam int          ANALOG_OUT_LSB    = 8;
    localparam int          IRQ_CTRL_EN_BIT   = 0;

endpackage : ppm_pkg

// ---- design/ppm_if.sv ----
`timescale 1ns/100ps
// ****************************************
// Override signals between pins and peripherals
// ****************************************
interface ppm_if;
    import ppm_pkg::*;

    // Per-pin overrides from the peripherals
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
    logic [7:0] dir_override_en;
    logic [7:0] dir_override_val;
    logic [7:0] value_override_en;
    logic [7:0] value_override_val;
    logic [7:0] toggle_override_en;
    logic [7:0] input_en_override_en;
    logic [7:0] input_en_override_val;
    logic [7:0] analog_out;
    logic [7:0] analog_oe;
    logic       ext_irq1_enable;

    // Taps from the pins
    logic [7:0] alt_sense_input;
    logic [7:0] analog_pad_line;
    logic [7:0] pin_change_src;
    logic       capture_trigger_in;
    logic       ext_irq1_in;
    logic       serial_clk_three_wire;
    logic       serial_data_in;

    modport pins (
        input  pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
        input  value_override_en, value_override_val, toggle_override_en,
        input  input_en_override_en, input_en_override_val, analog_out, analog_oe, ext_irq1_enable,
        output alt_sense_input, analog_pad_line, pin_change_src, capture_trigger_in,
        output ext_irq1_in, serial_clk_three_wire, serial_data_in
    );

    modport periph (
        output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
        output value_override_en, value_override_val, toggle_override_en,
        output input_en_override_en, input_en_override_val, analog_out, analog_oe, ext_irq1_enable,
        input  alt_sense_input, analog_pad_line, pin_change_src, capture_trigger_in,
        input  ext_irq1_in, serial_clk_three_wire, serial_data_in
    );

endinterface : ppm_if

// ---- design/ppm_port_pins.sv ----
`timescale 1ns/100ps
// Summary of operation
// - Pull-up override selects pull-up from value
// - Otherwise pull-up only for input, latch one, enabled
// - Direction override sets driver enable directly
// - Otherwise driver enable follows direction bit
// - Value override sets driven level
// - Otherwise driven level comes from latch
// - Toggle override inverts the output latch
// - Input-enable override sets input buffer enable
// - Otherwise input enable is cleared by sleep
// - Alternate input tapped before synchroniser
// - Analog line goes straight to pad
// - Strobes per port, globals shared, rest per pin
// - Peripherals generate overrides themselves
// - Each pin feeds its pin-change source
// - Bit 4 feeds the capture trigger
// - Bit 2 is ext interrupt and serial clock
// - Bit 1 can be serial data output
// - Bit 0 is serial data input/line
// - Comparator pins: input, pull-up off
// - Four cycles between write and readback of the pin
// - Sleep clamp lifted for enabled ext interrupt
// - Writing one to sample toggles latch
module ppm_port_pins
    import ppm_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,

    // Port register access, shared by all pins
    input  wire logic       port_wr_dir,
    input  wire logic       port_wr_latch,
    input  wire logic       port_wr_sample,
    input  wire logic [7:0] port_wdata,
    output logic      [7:0] port_dir,
    output logic      [7:0] port_latch,
    output logic      [7:0] port_sample,

    // Controls common to all ports
    input  wire logic       global_pullup_off,
    input  wire logic       sleep_clamp,

    // Digital pad
    input  wire logic [7:0] pad_in,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe,
    output logic      [7:0] pad_pullup_en,
    output logic      [7:0] pad_input_en,

    // Analog pad
    input  wire logic [7:0] pad_analog_in,
    output logic      [7:0] pad_analog_out,
    output logic      [7:0] pad_analog_oe,

    // Peripheral side
    ppm_if.pins             ovr
);

    // ****************************************
    // Override selection
    // ****************************************
    // Per bit: enable picks the override, else base
    function automatic logic [7:0] ovr_sel(
        input logic [7:0] en,
        input logic [7:0] val,
        input logic [7:0] base
    );
        ovr_sel = (en & val) | (~en & base);
    endfunction : ovr_sel

    // ****************************************
    // Pad controls
    // ****************************************
    // Kept combinational so the pads see overrides at once
    logic [7:0] pullup_base;
    logic [7:0] sleep_base;
    logic [7:0] irq_mask;

    assign pullup_base   = ~port_dir & port_latch & ~{NUM_PINS{global_pullup_off}};

    assign pad_pullup_en = ovr_sel(ovr.pullup_override_en, ovr.pullup_override_val,
                                   pullup_base);

    assign pad_oe        = ovr_sel(ovr.dir_override_en, ovr.dir_override_val,
                                   port_dir);

    assign pad_out       = ovr_sel(ovr.value_override_en, ovr.value_override_val,
                                   port_latch);

    // ****************************************
    // Input enable
    // ****************************************
    // An enabled external interrupt keeps its pin awake in sleep
    // Only the clamp is lifted; an override still wins
    assign irq_mask      = ovr.ext_irq1_enable ? PIN_EXT_IRQ1_MASK : PORT_RESET;
    assign sleep_base    = ~{NUM_PINS{sleep_clamp}} | irq_mask;
    assign pad_input_en  = ovr_sel(ovr.input_en_override_en, ovr.input_en_override_val,
                                   sleep_base);

    // ****************************************
    // Alternate function taps
    // ****************************************
    // Taken before the synchroniser; receivers must sync it
    assign ovr.alt_sense_input       = pad_in & pad_input_en;
    assign ovr.pin_change_src        = ovr.alt_sense_input;

    // Single-pin roles
    assign ovr.capture_trigger_in    = ovr.alt_sense_input[PIN_CAPTURE];
    assign ovr.ext_irq1_in           = ovr.alt_sense_input[PIN_EXT_IRQ1];
    assign ovr.serial_clk_three_wire = ovr.alt_sense_input[PIN_EXT_IRQ1];
    assign ovr.serial_data_in        = ovr.alt_sense_input[PIN_SERIAL_DATA];

    // ****************************************
    // Analog path
    // ****************************************
    // No digital gating; the far side resolves the wire
    assign ovr.analog_pad_line = pad_analog_in;
    assign pad_analog_out      = ovr.analog_out;
    assign pad_analog_oe       = ovr.analog_oe;

    // ****************************************
    // Direction and output latch
    // ****************************************
    logic [7:0] next_dir;
    logic [7:0] latch_base;
    logic [7:0] latch_flip;
    logic [7:0] next_latch;

    assign next_dir   = port_wr_dir ? port_wdata : port_dir;
    assign latch_base = port_wr_latch ? port_wdata : port_latch;
    // Either toggle source flips the bit once, never cancels
    assign latch_flip = (port_wr_sample ? port_wdata : PORT_RESET)
                      | ovr.toggle_override_en;

    assign next_latch = latch_base ^ latch_flip;

    // Reset leaves pins tri-stated
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_dir   <= PORT_RESET;
        end
        else
        begin
            port_dir   <= next_dir;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_latch <= PORT_RESET;
        end
        else
        begin
            port_latch <= next_latch;
        end
    end

    // ****************************************
    // Input synchroniser
    // ****************************************
    // Adds four cycles of delay before port_sample follows the pin after a write
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] sync_c;
    logic [7:0] next_sample;
    logic [7:0] sync_agree;

    // Each pin filtered on its own
    assign sync_agree  = ~(sync_b ^ sync_c);
    assign next_sample = ovr_sel(sync_agree, sync_c, port_sample);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a      <= PORT_RESET;
            sync_b      <= PORT_RESET;
            sync_c      <= PORT_RESET;
        end
        else
        begin
            // Only sync_b may read sync_a
            sync_a      <= ovr.alt_sense_input;
            sync_b      <= sync_a;
            sync_c      <= sync_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_sample <= PORT_RESET;
        end
        else
        begin
            port_sample <= next_sample;
        end
    end

endmodule : ppm_port_pins

// ---- design/ppm_periph_ovr.sv ----
`timescale 1ns/100ps
module ppm_periph_ovr
    import ppm_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,

    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // Pin side
    ppm_if.periph            ovr
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic        access;
    logic        wr_done;
    logic        hit_cfg;
    logic [31:0] rd_value;
    logic [7:0]  pu_en, pu_val, dir_en, dir_val, val_en, val_val, ie_en, ie_val;
    logic [15:0] analog;
    logic        irq_en;
    logic [7:0]  tog;
    logic [7:0]  st_a, st_b, st_c, status;

    assign access  = psel & penable;
    assign wr_done = access & pready & pwrite;
    assign hit_cfg = (paddr == REG_PULLUP_EN) || (paddr == REG_PULLUP_VAL) || (paddr == REG_DIR_EN)
                  || (paddr == REG_DIR_VAL) || (paddr == REG_VALUE_EN) || (paddr == REG_VALUE_VAL)
                  || (paddr == REG_TOGGLE) || (paddr == REG_INEN_EN) || (paddr == REG_INEN_VAL)
                  || (paddr == REG_ANALOG) || (paddr == REG_STATUS) || (paddr == REG_IRQ_CTRL);

    assign rd_value = (paddr == REG_PULLUP_EN)  ? {24'h000000, pu_en}   :
                      (paddr == REG_PULLUP_VAL) ? {24'h000000, pu_val}  :
                      (paddr == REG_DIR_EN)     ? {24'h000000, dir_en}  :
                      (paddr == REG_DIR_VAL)    ? {24'h000000, dir_val} :
                      (paddr == REG_VALUE_EN)   ? {24'h000000, val_en}  :
                      (paddr == REG_VALUE_VAL)  ? {24'h000000, val_val} :
                      (paddr == REG_INEN_EN)    ? {24'h000000, ie_en}   :
                      (paddr == REG_INEN_VAL)   ? {24'h000000, ie_val}  :
                      (paddr == REG_ANALOG)     ? {16'h0000, analog}    :
                      (paddr == REG_STATUS)     ? {24'h000000, status}  :
                      (paddr == REG_IRQ_CTRL)   ? {31'h00000000, irq_en} :
                      RDATA_RESET;

    // One wait state so read data comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'h0;
            prdata  <= RDATA_RESET;
            pslverr <= 1'h0;
        end
        else
        begin
            pready  <= access & ~pready;
            prdata  <= (access & ~pready & ~pwrite) ? rd_value : prdata;
            pslverr <= access & ~pready & ~hit_cfg;
        end
    end

    // ****************************************
    // Override registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pu_en   <= PORT_RESET;
            pu_val  <= PORT_RESET;
            dir_en  <= PORT_RESET;
            dir_val <= PORT_RESET;
            val_en  <= PORT_RESET;
            val_val <= PORT_RESET;
            ie_en   <= PORT_RESET;
            ie_val  <= PORT_RESET;
            analog  <= ANALOG_RESET;
            irq_en  <= 1'h0;
            tog     <= PORT_RESET;
        end
        else
        begin
            if (wr_done && paddr == REG_PULLUP_EN)  pu_en   <= pwdata[7:0];
            if (wr_done && paddr == REG_PULLUP_VAL) pu_val  <= pwdata[7:0];
            if (wr_done && paddr == REG_DIR_EN)     dir_en  <= pwdata[7:0];
            if (wr_done && paddr == REG_DIR_VAL)    dir_val <= pwdata[7:0];
            if (wr_done && paddr == REG_VALUE_EN)   val_en  <= pwdata[7:0];
            if (wr_done && paddr == REG_VALUE_VAL)  val_val <= pwdata[7:0];
            if (wr_done && paddr == REG_INEN_EN)    ie_en   <= pwdata[7:0];
            if (wr_done && paddr == REG_INEN_VAL)   ie_val  <= pwdata[7:0];
            if (wr_done && paddr == REG_ANALOG)     analog  <= pwdata[15:0];
            if (wr_done && paddr == REG_IRQ_CTRL)   irq_en  <= pwdata[IRQ_CTRL_EN_BIT];
            // Toggle request lasts one cycle per write
            tog <= (wr_done && paddr == REG_TOGGLE) ? pwdata[7:0] : PORT_RESET;
        end
    end

    // Overrides are produced here, per pin
    assign ovr.pullup_override_en    = pu_en;
    assign ovr.pullup_override_val   = pu_val;
    assign ovr.dir_override_en       = dir_en;
    assign ovr.dir_override_val      = dir_val;
    assign ovr.value_override_en     = val_en;
    assign ovr.value_override_val    = val_val;
    assign ovr.toggle_override_en    = tog;
    assign ovr.input_en_override_en  = ie_en;
    assign ovr.input_en_override_val = ie_val;
    assign ovr.analog_oe             = analog[ANALOG_OE_LSB +: 8];
    assign ovr.analog_out            = analog[ANALOG_OUT_LSB +: 8];
    assign ovr.ext_irq1_enable       = irq_en;

    // ****************************************
    // Own synchroniser on the raw taps
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_a   <= PORT_RESET;
            st_b   <= PORT_RESET;
            st_c   <= PORT_RESET;
            status <= PORT_RESET;
        end
        else
        begin
            st_a   <= ovr.alt_sense_input;
            st_b   <= st_a;
            st_c   <= st_b;
            status <= (st_c & ~(st_b ^ st_c)) | (status & (st_b ^ st_c));
        end
    end

endmodule : ppm_periph_ovr

// ---- dv/ppm_chk.sv ----
`timescale 1ns/100ps
// ****************************************
// Pin override checker
// ****************************************
module ppm_chk
(
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Port registers and pads
    input wire logic       port_wr_latch,
    input wire logic       port_wr_sample,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_latch,
    input wire logic       global_pullup_off,
    input wire logic       sleep_clamp,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_pullup_en,
    input wire logic [7:0] pad_input_en,
    input wire logic [7:0] pad_analog_in,
    // Override carrier
    input wire logic [7:0] pullup_override_en,
    input wire logic [7:0] pullup_override_val,
    input wire logic [7:0] dir_override_en,
    input wire logic [7:0] dir_override_val,
    input wire logic [7:0] value_override_en,
    input wire logic [7:0] value_override_val,
    input wire logic [7:0] toggle_override_en,
    input wire logic [7:0] input_en_override_en,
    input wire logic [7:0] input_en_override_val,
    input wire logic       ext_irq1_enable,
    input wire logic [7:0] alt_sense_input,
    input wire logic [7:0] analog_pad_line,
    input wire logic [7:0] pin_change_src,
    input wire logic       capture_trigger_in,
    input wire logic       ext_irq1_in,
    input wire logic       serial_clk_three_wire,
    input wire logic       serial_data_in
);
    wire logic [7:0] exp_pu = (pullup_override_en & pullup_override_val)
                            | (~pullup_override_en & ~port_dir & port_latch & {8{~global_pullup_off}});
    wire logic [7:0] exp_oe = (dir_override_en & dir_override_val) | (~dir_override_en & port_dir);
    wire logic [7:0] exp_val = (value_override_en & value_override_val) | (~value_override_en & port_latch);
    wire logic [7:0] exp_ie = (input_en_override_en & input_en_override_val)
                            | (~input_en_override_en & ({8{~sleep_clamp}} | {5'h00, ext_irq1_enable, 2'h0}));

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // Pad controls, same cycle as their cause
    // ****************************************
    pullup_sel_a: assert property (pad_pullup_en == exp_pu)
        else $error("pull-up enable mismatch");
    drive_en_a: assert property (pad_oe == exp_oe)
        else $error("driver enable mismatch");
    drive_val_a: assert property ((pad_out & pad_oe) == (exp_val & pad_oe))
        else $error("driven level mismatch");
    input_en_a: assert property (pad_input_en == exp_ie)
        else $error("input enable mismatch");
    irq_wake_a: assert property (ext_irq1_enable && !input_en_override_en[2] |-> pad_input_en[2])
        else $error("interrupt pin clamped");
    // ****************************************
    // Toggle and taps
    // ****************************************
    latch_toggle_a: assert property ((|toggle_override_en) && !port_wr_latch && !port_wr_sample
        |=> port_latch == ($past(port_latch) ^ $past(toggle_override_en))) else $error("latch not inverted");
    pulse_once_a: assert property ((|toggle_override_en) |=> toggle_override_en == 8'h00)
        else $error("toggle pulse too long");
    tap_point_a: assert property (alt_sense_input == (pad_in & pad_input_en))
        else $error("alternate input mismatch");
    analog_path_a: assert property (analog_pad_line == pad_analog_in)
        else $error("analog line mismatch");
    pcint_route_a: assert property (pin_change_src == alt_sense_input
        && capture_trigger_in == alt_sense_input[4]) else $error("pin change or capture route wrong");
    serial_route_a: assert property (ext_irq1_in == alt_sense_input[2] && serial_data_in == alt_sense_input[0]
        && serial_clk_three_wire == alt_sense_input[2]) else $error("serial route wrong");

    cover property (|toggle_override_en);
    cover property (ext_irq1_enable && sleep_clamp);
    cover property (|pullup_override_en);
endmodule : ppm_chk

// ---- dv/port_pin_override_mux_tb_top.sv ----
`timescale 1ns/100ps
module port_pin_override_mux_tb_top;
    import ppm_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        port_wr_dir = 1'b0, port_wr_latch = 1'b0, port_wr_sample = 1'b0;
    logic        global_pullup_off = 1'b0, sleep_clamp = 1'b0, pready, pslverr, err;
    logic [7:0]  port_wdata = 8'h00, pad_in = 8'h00, ext_analog = 8'h00;
    logic [7:0]  port_dir, port_latch, port_sample, pad_out, pad_oe, pad_pullup_en, pad_input_en;
    logic [7:0]  pad_analog_in, pad_analog_out, pad_analog_oe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    int          failures = 0, n_compared = 0;

    ppm_if ifc ();
    always #2 pclk = ~pclk;
    // Far side drives the analog pad only where the peripheral does not
    assign pad_analog_in = (pad_analog_oe & pad_analog_out) | (~pad_analog_oe & ext_analog);

    ppm_port_pins u_ppm_port_pins (.pclk, .presetn, .port_wr_dir, .port_wr_latch, .port_wr_sample, .port_wdata,
        .port_dir, .port_latch, .port_sample, .global_pullup_off, .sleep_clamp, .pad_in, .pad_out, .pad_oe,
        .pad_pullup_en, .pad_input_en, .pad_analog_in, .pad_analog_out, .pad_analog_oe, .ovr(ifc));
    ppm_periph_ovr u_ppm_periph_ovr (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ovr(ifc));
    ppm_chk u_chk (.pclk, .presetn, .port_wr_latch, .port_wr_sample, .port_dir, .port_latch, .global_pullup_off,
        .sleep_clamp, .pad_in, .pad_oe, .pad_out, .pad_pullup_en, .pad_input_en, .pad_analog_in,
        .pullup_override_en(ifc.pullup_override_en), .pullup_override_val(ifc.pullup_override_val),
        .dir_override_en(ifc.dir_override_en), .dir_override_val(ifc.dir_override_val),
        .value_override_en(ifc.value_override_en), .value_override_val(ifc.value_override_val),
        .toggle_override_en(ifc.toggle_override_en), .input_en_override_en(ifc.input_en_override_en),
        .input_en_override_val(ifc.input_en_override_val), .ext_irq1_enable(ifc.ext_irq1_enable),
        .alt_sense_input(ifc.alt_sense_input), .analog_pad_line(ifc.analog_pad_line),
        .pin_change_src(ifc.pin_change_src), .capture_trigger_in(ifc.capture_trigger_in),
        .ext_irq1_in(ifc.ext_irq1_in), .serial_clk_three_wire(ifc.serial_clk_three_wire),
        .serial_data_in(ifc.serial_data_in));

    // ****************************************
    // Shared tasks
    // ****************************************
    task give_verdict;
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Sample where the edge's updates have landed
    task wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wait_cyc

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n == 20)
        begin
            failures++;
            give_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task port_wr(input int kind, input logic [7:0] d);
        @(posedge pclk);
        port_wdata <= d;
        port_wr_dir <= (kind == 0);
        port_wr_latch <= (kind == 1);
        port_wr_sample <= (kind == 2);
        @(posedge pclk);
        port_wr_dir <= 1'b0;
        port_wr_latch <= 1'b0;
        port_wr_sample <= 1'b0;
    endtask : port_wr

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        wait_cyc(1);
        chk("pad_oe", 8'h00, pad_oe);
        chk("pad_pullup_en", 8'h00, pad_pullup_en);
        chk("pad_input_en", 8'hff, pad_input_en);
        apb(1'b0, REG_PULLUP_EN, 32'h0);
        chk("pullup_en reg", 32'h0, rd);
    endtask : t_reset

    task t_plain;
        port_wr(0, 8'h0f);
        port_wr(1, 8'h33);
        wait_cyc(1);
        chk("pad_oe", 8'h0f, pad_oe);
        chk("pad_pullup_en", 8'h30, pad_pullup_en);
        chk("pad_out", 8'h03, pad_out & pad_oe);
        @(posedge pclk) global_pullup_off <= 1'b1;
        wait_cyc(1);
        chk("pad_pullup_en", 8'h00, pad_pullup_en);
        @(posedge pclk) global_pullup_off <= 1'b0;
    endtask : t_plain

    task t_override;
        apb(1'b1, REG_PULLUP_VAL, 32'h5a);
        apb(1'b1, REG_PULLUP_EN, 32'hff);
        #1 chk("pad_pullup_en", 8'h5a, pad_pullup_en);
        apb(1'b1, REG_DIR_VAL, 32'ha5);
        apb(1'b1, REG_DIR_EN, 32'hf0);
        #1 chk("pad_oe", 8'haf, pad_oe);
        apb(1'b1, REG_VALUE_VAL, 32'h3c);
        apb(1'b1, REG_VALUE_EN, 32'hff);
        #1 chk("pad_out", 8'h2c, pad_out & pad_oe);
        chk("pslverr", 1'b0, err);
        apb(1'b1, REG_PULLUP_EN, 32'h0);
        apb(1'b1, REG_DIR_EN, 32'h0);
        apb(1'b1, REG_VALUE_EN, 32'h0);
        apb(1'b0, REG_DIR_VAL, 32'h0);
        chk("dir_val reg", 32'ha5, rd);
    endtask : t_override

    task t_toggle;
        apb(1'b1, REG_TOGGLE, 32'h81);
        wait_cyc(3);
        chk("port_latch", 8'hb2, port_latch);
        apb(1'b0, REG_TOGGLE, 32'h0);
        chk("toggle reg", 32'h0, rd);
        port_wr(2, 8'h0f);
        wait_cyc(1);
        chk("port_latch", 8'hbd, port_latch);
    endtask : t_toggle

    task t_input;
        @(posedge pclk) pad_in <= 8'ha5;
        wait_cyc(1);
        chk("alt_sense_input", 8'ha5, ifc.alt_sense_input);
        chk("pin_change_src", 8'ha5, ifc.pin_change_src);
        chk("taps", 4'b0111, {ifc.capture_trigger_in, ifc.ext_irq1_in,
            ifc.serial_clk_three_wire, ifc.serial_data_in});
        wait_cyc(4);
        chk("port_sample", 8'ha5, port_sample);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status reg", 32'ha5, rd);
        @(posedge pclk) sleep_clamp <= 1'b1;
        wait_cyc(1);
        chk("pad_input_en", 8'h00, pad_input_en);
        apb(1'b1, REG_INEN_VAL, 32'h0b);
        apb(1'b1, REG_INEN_EN, 32'h33);
        #1 chk("pad_input_en", 8'h03, pad_input_en);
        apb(1'b1, REG_IRQ_CTRL, 32'h1);
        #1 chk("pad_input_en", 8'h07, pad_input_en);
        apb(1'b1, REG_INEN_EN, 32'h37);
        #1 chk("pad_input_en", 8'h03, pad_input_en);
        apb(1'b1, REG_INEN_EN, 32'h0);
        apb(1'b1, REG_IRQ_CTRL, 32'h0);
        @(posedge pclk) sleep_clamp <= 1'b0;
    endtask : t_input

    task t_analog;
        @(posedge pclk) ext_analog <= 8'hc3;
        global_pullup_off <= 1'b1;
        apb(1'b1, REG_ANALOG, 32'h050f);
        #1 chk("analog_pad_line", 8'hc5, ifc.analog_pad_line);
        chk("pad_pullup_en", 8'h00, pad_pullup_en);
        apb(1'b0, REG_ANALOG, 32'h0);
        chk("analog reg", 32'h050f, rd);
    endtask : t_analog

    // Unmapped place: refused, no side effect
    task t_unmapped;
        apb(1'b1, 12'h030, 32'hffff_ffff);
        chk("pslverr", 1'b1, err);
        apb(1'b0, 12'h030, 32'h0);
        chk("pslverr", 1'b1, err);
        chk("unmapped read", 32'h0, rd);
        apb(1'b0, REG_DIR_VAL, 32'h0);
        chk("dir_val reg", 32'ha5, rd);
    endtask : t_unmapped

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_plain;
        t_override;
        t_toggle;
        t_input;
        t_analog;
        t_unmapped;
        give_verdict;
    end
endmodule : port_pin_override_mux_tb_top
